// ==== verilog/lcp_map.svh ====
// Register offsets, field positions, reset values and timing for the link config and protection bank
`ifndef LCP_MAP_SVH
`define LCP_MAP_SVH

// Register byte offsets
`define LCP_ADDR_IMMUNITY     8'h17
`define LCP_ADDR_RSVD_A       8'h18
`define LCP_ADDR_RSVD_B       8'h19
`define LCP_ADDR_RATE_PIN     8'h1A
`define LCP_ADDR_AUDIO_POL    8'h1B
`define LCP_ADDR_IDENT        8'h1E
`define LCP_ADDR_CAP_REV      8'h1F
`define LCP_ADDR_RX_KEY       8'h80
`define LCP_ADDR_LINK_CHK     8'h85
`define LCP_ADDR_ENH_CHK      8'h87
`define LCP_ADDR_SESSION      8'h88
`define LCP_ADDR_TX_KEY       8'h90
`define LCP_ADDR_PCTRL        8'h95
`define LCP_ADDR_FORCE_COLOUR 8'h9D

// Register sizes in bytes
`define LCP_RX_KEY_BYTES      5
`define LCP_LINK_CHK_BYTES    2
`define LCP_SESSION_BYTES     8
`define LCP_TX_KEY_BYTES      5
`define LCP_FORCE_BYTES       3

// Field positions
`define LCP_BIT_IMMUNITY      7
`define LCP_BIT_RATE          7
`define LCP_BIT_PIN_A         5
`define LCP_BIT_PIN_B         4
`define LCP_BIT_ARB           0
`define LCP_BIT_SCK_INV       7
`define LCP_BIT_WS_INV        6
`define LCP_BIT_PROTECTION_CAPABLE_FLAG          4
`define LCP_BIT_PWR_DOWN      7
`define LCP_BIT_INT_COMP      6
`define LCP_BIT_FORCE_AUDIO   5
`define LCP_BIT_FORCE_VIDEO   4
`define LCP_BIT_PROT_RESET    3
`define LCP_BIT_AUTH_START    2
`define LCP_BIT_FRAME_SYNC    1
`define LCP_BIT_ENCRYPT       0

// Reset and fixed values
`define LCP_RST_IMMUNITY_LOW  7'h1F
`define LCP_RST_RSVD_B        8'h4A
`define LCP_RST_AUDIO_LOW     6'h10
`define LCP_RST_LINK_CHK      16'hFFFF
`define LCP_RST_ENH_CHK       8'hFF
`define LCP_RST_PCTRL         8'h00

// Timing
`define LCP_CLK_PERIOD_NS     100
`define LCP_ARB_SHORT_NS      256000
`define LCP_ARB_LONG_NS       4000000

`endif

// ==== verilog/lcp_pkg.sv ====
// Types shared by the link config and protection register bank
package lcp_pkg;

  // One register access from the control channel
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lcp_reg_req_t;

  // One pixel, red in the low byte
  typedef struct packed {
    logic [7:0] blue;
    logic [7:0] green;
    logic [7:0] red;
  } lcp_video_t;

  // Arbitration timer states
  typedef enum logic {
    LCP_ARB_IDLE,
    LCP_ARB_RUN
  } lcp_arb_state_t;

endpackage : lcp_pkg

// ==== verilog/lcp_link_config_protect_regs.sv ====
// Register bank for reverse-channel, pin-function, audio polarity, identity and protection control
`timescale 1ns/1ps
`default_nettype none
`include "lcp_map.svh"

module lcp_link_config_protect_regs
  import lcp_pkg::*;
#(
  parameter int unsigned ARB_LONG_CYCLES = `LCP_ARB_LONG_NS / `LCP_CLK_PERIOD_NS,
  parameter logic [7:0]  DEVICE_ID       = 8'hA5,  // Arbitrary value
  parameter logic [3:0]  REVISION        = 4'h1,   // Arbitrary value
  parameter logic        CAPABLE         = 1'b1,
  parameter int unsigned AUDIO_W         = 32
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire lcp_reg_req_t         reg_req,
  output logic [7:0]                reg_rdata,
  output logic                      reg_rvalid,
  input  wire logic                 output_immunity_strap_pin,
  input  wire logic                 mode_or_control_a_pin,
  input  wire logic                 dual_function_control_b_pin,
  input  wire logic                 vsync_pin,
  input  wire logic                 audio_sck_pin,
  input  wire logic                 audio_ws_pin,
  output logic                      reverse_immunity_select,
  output logic                      reverse_rate_select,
  output logic                      mode_select_in,
  output logic                      control_a_in,
  output logic                      native_b_in,
  output logic                      control_b_in,
  input  wire logic                 coax_splitter_mode,
  input  wire logic                 arb_start,
  input  wire logic                 arb_cancel,
  output logic                      arb_timeout,
  output logic                      audio_sck_out,
  output logic                      audio_ws_out,
  input  wire logic [AUDIO_W-1:0]   audio_data_in,
  output logic [AUDIO_W-1:0]        audio_data_out,
  input  wire lcp_video_t           video_in,
  output lcp_video_t                video_out,
  input  wire logic [15:0]          tx_link_check,
  input  wire logic [7:0]           tx_enh_check,
  input  wire logic [63:0]          session_random_number,
  input  wire logic [39:0]          transmitter_key_vector,
  input  wire logic                 prot_reset_done,
  input  wire logic                 auth_started,
  output logic [7:0]                protection_control,
  output logic [39:0]               receiver_key_vector,
  output logic [15:0]               rx_link_check,
  output logic [7:0]                rx_enh_check,
  output logic                      link_check_match,
  output logic                      enh_check_match
);

  localparam int unsigned ARB_SHORT_CYCLES = `LCP_ARB_SHORT_NS / `LCP_CLK_PERIOD_NS;
  localparam int          NSYNC            = 6;

  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic             vsync_prev;
  logic [1:0]       strap_cnt;
  logic             strap_done;
  logic             audio_sck_invert;
  logic             word_select_invert;
  logic             arbitration_timeout_select;
  logic             shared_pin_a_select;
  logic             shared_pin_b_select;
  logic [23:0]      forced_colour_value;
  lcp_arb_state_t   arb_state;
  logic [15:0]      arb_count;
  logic [7:0]       next_rdata;
  logic [7:0]       rd_off;
  logic             wr_pctrl;
  logic             int_comp;
  logic             vsync_fall;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  assign pin_raw    = {audio_ws_pin, audio_sck_pin, vsync_pin, dual_function_control_b_pin,
                       mode_or_control_a_pin, output_immunity_strap_pin};
  assign wr_pctrl   = reg_req.wr && (reg_req.addr == `LCP_ADDR_PCTRL);
  assign int_comp   = protection_control[`LCP_BIT_INT_COMP];
  assign vsync_fall = vsync_prev && !sync2[3];

  //////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for every pin
  generate
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          sync1[i] <= 1'b0;
          sync2[i] <= 1'b0;
        end else begin
          sync1[i] <= pin_raw[i];
          sync2[i] <= sync1[i];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Strap capture once the synchroniser has filled after reset release
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strap_cnt  <= 2'h0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == 2'h2) begin
        strap_done <= 1'b1;
      end
    end
  end

  // Immunity mode: strap value at power-up, then software
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reverse_immunity_select <= 1'b0;
    end else if (reg_req.wr && reg_req.addr == `LCP_ADDR_IMMUNITY) begin
      reverse_immunity_select <= reg_req.wdata[`LCP_BIT_IMMUNITY];
    end else if (!strap_done && strap_cnt == 2'h2) begin
      reverse_immunity_select <= sync2[0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Rate, pin-select and arbitration bits; audio polarity bits
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reverse_rate_select        <= 1'b0;
      shared_pin_a_select        <= 1'b0;
      shared_pin_b_select        <= 1'b0;
      arbitration_timeout_select <= 1'b0;
      audio_sck_invert           <= 1'b0;
      word_select_invert         <= 1'b0;
    end else if (reg_req.wr && reg_req.addr == `LCP_ADDR_RATE_PIN) begin
      reverse_rate_select        <= reg_req.wdata[`LCP_BIT_RATE];
      shared_pin_a_select        <= reg_req.wdata[`LCP_BIT_PIN_A];
      shared_pin_b_select        <= reg_req.wdata[`LCP_BIT_PIN_B];
      arbitration_timeout_select <= reg_req.wdata[`LCP_BIT_ARB];
    end else if (reg_req.wr && reg_req.addr == `LCP_ADDR_AUDIO_POL) begin
      audio_sck_invert   <= reg_req.wdata[`LCP_BIT_SCK_INV];
      word_select_invert <= reg_req.wdata[`LCP_BIT_WS_INV];
    end
  end

  // Shared input routing
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_select_in <= 1'b0;
      control_a_in   <= 1'b0;
      native_b_in    <= 1'b0;
      control_b_in   <= 1'b0;
    end else begin
      mode_select_in <= shared_pin_a_select ? 1'b0 : sync2[1];
      control_a_in   <= shared_pin_a_select ? sync2[1] : 1'b0;
      native_b_in    <= shared_pin_b_select ? 1'b0 : sync2[2];
      control_b_in   <= shared_pin_b_select ? sync2[2] : 1'b0;
    end
  end

  // Audio clock and word select with optional inversion
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      audio_sck_out <= 1'b0;
      audio_ws_out  <= 1'b0;
    end else begin
      audio_sck_out <= sync2[4] ^ audio_sck_invert;
      audio_ws_out  <= sync2[5] ^ word_select_invert;
    end
  end

  a_sck_invert : assert property (1 |=> audio_sck_out == ($past(sync2[4]) ^ $past(audio_sck_invert)))
    else $error("serial clock polarity wrong");
  a_ws_invert : assert property (1 |=> audio_ws_out == ($past(sync2[5]) ^ $past(word_select_invert)))
    else $error("word select polarity wrong");

  //////////////////////////////////////////////////////////////////////////////
  // Reverse-channel arbitration timer, splitter mode only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arb_state   <= LCP_ARB_IDLE;
      arb_count   <= 16'h0000;
      arb_timeout <= 1'b0;
    end else begin
      arb_timeout <= 1'b0;
      case (arb_state)
        LCP_ARB_IDLE: begin
          if (arb_start && coax_splitter_mode) begin
            arb_state <= LCP_ARB_RUN;
            arb_count <= arbitration_timeout_select ? 16'(ARB_LONG_CYCLES - 1)
                                                    : 16'(ARB_SHORT_CYCLES - 1);
          end
        end
        LCP_ARB_RUN: begin
          if (arb_cancel || !coax_splitter_mode) begin
            arb_state <= LCP_ARB_IDLE;
          end else if (arb_count == 16'h0000) begin
            arb_timeout <= 1'b1;
            arb_state   <= LCP_ARB_IDLE;
          end else begin
            arb_count <= arb_count - 16'h0001;
          end
        end
        default: arb_state <= LCP_ARB_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Writable multi-byte registers: receiver key, forced colour, receiver link check value
  generate
    for (genvar i = 0; i < `LCP_RX_KEY_BYTES; i++) begin : g_rx_key
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          receiver_key_vector[8*i +: 8] <= 8'h00;
        end else if (reg_req.wr && reg_req.addr == 8'(`LCP_ADDR_RX_KEY + i)) begin
          receiver_key_vector[8*i +: 8] <= reg_req.wdata;
        end
      end
    end
    for (genvar i = 0; i < `LCP_FORCE_BYTES; i++) begin : g_force
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          forced_colour_value[8*i +: 8] <= 8'h00;
        end else if (reg_req.wr && reg_req.addr == 8'(`LCP_ADDR_FORCE_COLOUR + i)) begin
          forced_colour_value[8*i +: 8] <= reg_req.wdata;
        end
      end
    end
    for (genvar i = 0; i < `LCP_LINK_CHK_BYTES; i++) begin : g_link_chk
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          rx_link_check[8*i +: 8] <= 8'(`LCP_RST_LINK_CHK >> (8*i));
        end else if (int_comp && reg_req.wr && reg_req.addr == 8'(`LCP_ADDR_LINK_CHK + i)) begin
          rx_link_check[8*i +: 8] <= reg_req.wdata;
        end
      end
    end
  endgenerate

  // Enhanced receiver check value, writable only with internal compare
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_enh_check <= `LCP_RST_ENH_CHK;
    end else if (int_comp && reg_req.wr && reg_req.addr == `LCP_ADDR_ENH_CHK) begin
      rx_enh_check <= reg_req.wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Protection control: plain bits, self-clearing strobes, sticky frame sync
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      protection_control <= `LCP_RST_PCTRL;
      vsync_prev         <= 1'b0;
    end else begin
      vsync_prev <= sync2[3];
      if (wr_pctrl) begin
        protection_control[`LCP_BIT_PWR_DOWN]    <= reg_req.wdata[`LCP_BIT_PWR_DOWN];
        protection_control[`LCP_BIT_INT_COMP]    <= reg_req.wdata[`LCP_BIT_INT_COMP];
        protection_control[`LCP_BIT_FORCE_AUDIO] <= reg_req.wdata[`LCP_BIT_FORCE_AUDIO];
        protection_control[`LCP_BIT_FORCE_VIDEO] <= reg_req.wdata[`LCP_BIT_FORCE_VIDEO];
        protection_control[`LCP_BIT_ENCRYPT]     <= reg_req.wdata[`LCP_BIT_ENCRYPT];
      end
      // Reset strobe: write of 1 wins over completion
      if (wr_pctrl && reg_req.wdata[`LCP_BIT_PROT_RESET]) begin
        protection_control[`LCP_BIT_PROT_RESET] <= 1'b1;
      end else if (prot_reset_done) begin
        protection_control[`LCP_BIT_PROT_RESET] <= 1'b0;
      end
      // Start strobe: write of 1 wins over started
      if (wr_pctrl && reg_req.wdata[`LCP_BIT_AUTH_START]) begin
        protection_control[`LCP_BIT_AUTH_START] <= 1'b1;
      end else if (auth_started) begin
        protection_control[`LCP_BIT_AUTH_START] <= 1'b0;
      end
      // Frame sync: detection wins over a write of 0
      if (vsync_fall) begin
        protection_control[`LCP_BIT_FRAME_SYNC] <= 1'b1;
      end else if (wr_pctrl && !reg_req.wdata[`LCP_BIT_FRAME_SYNC]) begin
        protection_control[`LCP_BIT_FRAME_SYNC] <= 1'b0;
      end
    end
  end

  a_reset_clears : assert property (protection_control[`LCP_BIT_PROT_RESET] && prot_reset_done &&
                                    !wr_pctrl |=> !protection_control[`LCP_BIT_PROT_RESET])
    else $error("protection reset bit did not self-clear");
  a_start_clears : assert property (protection_control[`LCP_BIT_AUTH_START] && auth_started &&
                                    !(wr_pctrl && reg_req.wdata[`LCP_BIT_AUTH_START])
                                    |=> !protection_control[`LCP_BIT_AUTH_START])
    else $error("start bit did not self-clear");
  a_frame_sync_set : assert property ($fell(sync2[3]) |=> protection_control[`LCP_BIT_FRAME_SYNC])
    else $error("falling vertical sync not flagged");

  //////////////////////////////////////////////////////////////////////////////
  // Audio and video forcing
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      audio_data_out <= '0;
      video_out      <= '0;
    end else begin
      audio_data_out <= protection_control[`LCP_BIT_FORCE_AUDIO] ? '0 : audio_data_in;
      video_out      <= protection_control[`LCP_BIT_FORCE_VIDEO] ? lcp_video_t'(forced_colour_value)
                                                                 : video_in;
    end
  end

  a_audio_force : assert property (protection_control[`LCP_BIT_FORCE_AUDIO] |=> audio_data_out == '0)
    else $error("forced audio not zero");
  a_video_force : assert property (protection_control[`LCP_BIT_FORCE_VIDEO]
                                   |=> video_out.red == $past(forced_colour_value[7:0]) &&
                                       video_out.green == $past(forced_colour_value[15:8]) &&
                                       video_out.blue == $past(forced_colour_value[23:16]))
    else $error("forced colour not sent");

  //////////////////////////////////////////////////////////////////////////////
  // Internal compare match flags
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      link_check_match <= 1'b0;
      enh_check_match  <= 1'b0;
    end else begin
      link_check_match <= int_comp && (rx_link_check == tx_link_check);
      enh_check_match  <= int_comp && (rx_enh_check == tx_enh_check);
    end
  end

  a_match_cleared : assert property (!int_comp |=> !link_check_match && !enh_check_match)
    else $error("match flag set without internal compare");

  //////////////////////////////////////////////////////////////////////////////
  // Read data multiplexer; read-only fields never take write data
  always_comb begin
    next_rdata = 8'h00;
    rd_off     = 8'h00;
    if (reg_req.addr == `LCP_ADDR_IMMUNITY) begin
      next_rdata = {reverse_immunity_select, `LCP_RST_IMMUNITY_LOW};
    end else if (reg_req.addr == `LCP_ADDR_RSVD_B) begin
      next_rdata = `LCP_RST_RSVD_B;
    end else if (reg_req.addr == `LCP_ADDR_RATE_PIN) begin
      next_rdata = {reverse_rate_select, 1'b0, shared_pin_a_select, shared_pin_b_select,
                    3'h0, arbitration_timeout_select};
    end else if (reg_req.addr == `LCP_ADDR_AUDIO_POL) begin
      next_rdata = {audio_sck_invert, word_select_invert, `LCP_RST_AUDIO_LOW};
    end else if (reg_req.addr == `LCP_ADDR_IDENT) begin
      next_rdata = DEVICE_ID;
    end else if (reg_req.addr == `LCP_ADDR_CAP_REV) begin
      next_rdata = {3'h0, CAPABLE, REVISION};
    end else if (reg_req.addr >= `LCP_ADDR_RX_KEY && reg_req.addr < `LCP_ADDR_LINK_CHK) begin
      rd_off     = reg_req.addr - `LCP_ADDR_RX_KEY;
      next_rdata = receiver_key_vector[8*rd_off[2:0] +: 8];
    end else if (reg_req.addr >= `LCP_ADDR_LINK_CHK && reg_req.addr < `LCP_ADDR_ENH_CHK) begin
      rd_off     = reg_req.addr - `LCP_ADDR_LINK_CHK;
      next_rdata = int_comp ? rx_link_check[8*rd_off[0] +: 8]
                            : tx_link_check[8*rd_off[0] +: 8];
    end else if (reg_req.addr == `LCP_ADDR_ENH_CHK) begin
      next_rdata = int_comp ? rx_enh_check : tx_enh_check;
    end else if (reg_req.addr >= `LCP_ADDR_SESSION && reg_req.addr < `LCP_ADDR_TX_KEY) begin
      rd_off     = reg_req.addr - `LCP_ADDR_SESSION;
      next_rdata = session_random_number[8*rd_off[2:0] +: 8];
    end else if (reg_req.addr >= `LCP_ADDR_TX_KEY && reg_req.addr < `LCP_ADDR_PCTRL) begin
      rd_off     = reg_req.addr - `LCP_ADDR_TX_KEY;
      next_rdata = transmitter_key_vector[8*rd_off[2:0] +: 8];
    end else if (reg_req.addr == `LCP_ADDR_PCTRL) begin
      next_rdata = protection_control;
    end else if (reg_req.addr >= `LCP_ADDR_FORCE_COLOUR &&
                 reg_req.addr < 8'(`LCP_ADDR_FORCE_COLOUR + `LCP_FORCE_BYTES)) begin
      rd_off     = reg_req.addr - `LCP_ADDR_FORCE_COLOUR;
      next_rdata = forced_colour_value[8*rd_off[1:0] +: 8];
    end
  end

  // Registered read answer, one cycle after the request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  a_link_check_read : assert property (reg_req.rd && reg_req.addr == `LCP_ADDR_LINK_CHK && !int_comp
                                       |=> reg_rvalid && reg_rdata == $past(tx_link_check[7:0]))
    else $error("link check read did not return transmitter value");
  a_ident_fixed : assert property (reg_req.rd && reg_req.addr == `LCP_ADDR_IDENT
                                   |=> reg_rdata == DEVICE_ID)
    else $error("identifier read wrong");

endmodule : lcp_link_config_protect_regs

`default_nettype wire

// ==== dv/lcp_mcu_model.sv ====
// Microcontroller model issuing byte accesses over the control channel
`timescale 1ns/1ps
`default_nettype none
module lcp_mcu_model
  import lcp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output lcp_reg_req_t    reg_req
);
  initial reg_req = '0;
  // Byte write, strobe held for one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    reg_req <= '0;
    @(posedge sys_clk);
  endtask : wr
  // Byte read, returns valid flag and data
  task automatic rd(input logic [7:0] a, output logic [8:0] r);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk);
    reg_req <= '0;
    @(posedge sys_clk);
    r = {reg_rvalid, reg_rdata};
  endtask : rd
endmodule : lcp_mcu_model
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the link config and protection register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lcp_pkg::*;
  logic sys_clk = 0, rst = 1, output_immunity_strap_pin = 1, mode_or_control_a_pin = 0;
  logic dual_function_control_b_pin = 0, vsync_pin = 0, audio_sck_pin = 0, audio_ws_pin = 0;
  logic coax_splitter_mode = 1, arb_start = 0, arb_cancel = 0, prot_reset_done = 0, auth_started = 0;
  logic reg_rvalid, reverse_immunity_select, reverse_rate_select, mode_select_in, control_a_in, native_b_in;
  logic control_b_in, arb_timeout, audio_sck_out, audio_ws_out, link_check_match, enh_check_match;
  logic [7:0] reg_rdata, protection_control, rx_enh_check, tx_enh_check;
  logic [15:0] rx_link_check, tx_link_check;
  logic [31:0] audio_data_in = 0, audio_data_out;
  logic [39:0] receiver_key_vector, transmitter_key_vector;
  logic [63:0] session_random_number;
  lcp_reg_req_t reg_req;
  lcp_video_t video_in = 0, video_out;
  int bad_count = 0, n_checks = 0;
  lcp_link_config_protect_regs #(.ARB_LONG_CYCLES(50)) u_dut (.*);
  lcp_mcu_model u_mcu (.*);
  always #50 sys_clk = ~sys_clk;
  // Fresh random traffic every cycle
  always @(posedge sys_clk) begin
    audio_data_in <= $urandom;
    video_in <= $urandom;
    vsync_pin <= $urandom;
  end
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic summarize();
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // Watchdog against a hung run
  initial begin
    #1000000;
    bad_count++;
    summarize();
  end
  // Main sequence
  initial begin
    logic [8:0] r;
    logic [7:0] d;
    logic [23:0] col;
    int n;
    void'($urandom(21));
    {tx_link_check, tx_enh_check, col} = {$urandom, $urandom};
    session_random_number = {$urandom, $urandom};
    transmitter_key_vector = {$urandom, $urandom};
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    repeat (4) @(posedge sys_clk);
    u_mcu.rd(8'h17, r); chk({r, reverse_immunity_select}, {9'h19F, 1'b1});
    u_mcu.rd(8'h95, r); chk(r & 9'h1FD, 9'h100);
    u_mcu.rd(8'h85, r); chk(r, {1'b1, tx_link_check[7:0]});
    u_mcu.rd(8'h87, r); chk(r, {1'b1, tx_enh_check});
    chk({rx_link_check, rx_enh_check}, 24'hFFFFFF);
    u_mcu.wr(8'h1E, $urandom); u_mcu.rd(8'h1E, r); chk(r, 9'h1A5);
    u_mcu.rd(8'h1F, r); chk(r, 9'h111);
    // Receiver key bytes hold writes; session bytes ignore them
    for (int i = 0; i < 5; i++) begin
      d = $urandom;
      u_mcu.wr(8'h80 + i[7:0], d); u_mcu.rd(8'h80 + i[7:0], r);
      chk({r, receiver_key_vector[8*i +: 8]}, {1'b1, d, d});
      u_mcu.wr(8'h88 + i[7:0], ~d); u_mcu.rd(8'h88 + i[7:0], r);
      chk(r, {1'b1, session_random_number[8*i +: 8]});
    end
    // Link check writes refused while compare is off
    u_mcu.wr(8'h85, ~tx_link_check[7:0]); chk(rx_link_check, 16'hFFFF);
    // Every pin route and polarity code
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      {mode_or_control_a_pin, dual_function_control_b_pin, audio_sck_pin, audio_ws_pin} <= d[3:0];
      u_mcu.wr(8'h1A, {d[7], 1'b0, i[1:0], 4'h0});
      u_mcu.wr(8'h1B, {i[1:0], 6'h10});
      repeat (4) @(posedge sys_clk);
      chk({mode_select_in, control_a_in, native_b_in, control_b_in, reverse_rate_select}, {~i[1] & d[3],
          i[1] & d[3], ~i[0] & d[2], i[0] & d[2], d[7]});
      chk({audio_sck_out, audio_ws_out}, {d[1] ^ i[1], d[0] ^ i[0]});
    end
    u_mcu.wr(8'h9D, col[7:0]); u_mcu.wr(8'h9E, col[15:8]); u_mcu.wr(8'h9F, col[23:16]);
    u_mcu.wr(8'h95, 8'h30);
    repeat (2) @(posedge sys_clk);
    chk({audio_data_out, video_out}, {32'h0, col});
    // Internal compare with receiver values
    u_mcu.wr(8'h95, 8'h40);
    u_mcu.wr(8'h85, tx_link_check[7:0]); u_mcu.wr(8'h86, tx_link_check[15:8]); u_mcu.wr(8'h87, ~tx_enh_check);
    u_mcu.rd(8'h87, r); chk(r, {1'b1, ~tx_enh_check});
    chk({link_check_match, enh_check_match}, 2'b10);
    u_mcu.wr(8'h95, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk({link_check_match, enh_check_match}, 2'b00);
    // Self-clearing strobes beside plain bits
    u_mcu.wr(8'h95, 8'h8D); u_mcu.rd(8'h95, r); chk(r & 9'h1FD, 9'h18D);
    prot_reset_done <= 1; auth_started <= 1;
    @(posedge sys_clk);
    prot_reset_done <= 0; auth_started <= 0;
    repeat (2) @(posedge sys_clk);
    u_mcu.rd(8'h95, r); chk(r & 9'h1FD, 9'h181);
    // Long arbitration timeout in splitter mode
    u_mcu.wr(8'h1A, 8'h01);
    arb_start <= 1;
    @(posedge sys_clk);
    arb_start <= 0;
    n = 0;
    while (arb_timeout !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n, 51);
    summarize();
  end
endmodule : testbench
`default_nettype wire
